// >>> adcseq_avg.sv
// Purpose: sixteen-sample averager with bypass
// Assumes: samples of one channel arrive until a result leaves
// Notes: result one cycle after the last sample
`timescale 1ns/1ps
module adcseq_avg
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // samples in, results out
  adcseq_avg_if.avg aif
);
  import adcseq_pkg::*;
  typedef struct packed {
    logic [13:0] sum;
    logic [3:0] cnt;
    logic res_valid;
    logic [9:0] res_data;
  } adcseq_avg_t;
  adcseq_avg_t r;
  adcseq_avg_t n;
  logic [13:0] total;
  always_comb
  begin
    n = r;
    n.res_valid = 1'b0;
    total = 14'(r.sum + {4'h0, aif.smp_data});
    if (aif.smp_valid)
    begin
      if (aif.avg_off)
      begin
        n.res_valid = 1'b1;
        n.res_data = aif.smp_data;
        n.sum = '0;
        n.cnt = '0;
      end
      else if (r.cnt == 4'(AVG_COUNT - 1))
      begin
        n.res_valid = 1'b1;
        n.res_data = total[AVG_SHIFT +: 10];
        n.sum = '0;
        n.cnt = '0;
      end
      else
      begin
        n.sum = total;
        n.cnt = 4'(r.cnt + 1'b1);
      end
    end
  end
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      r <= '0;
    else
      r <= n;
  end
  assign aif.res_valid = r.res_valid;
  assign aif.res_data = r.res_data;
endmodule : adcseq_avg

// >>> adcseq_avg_if.sv
// Purpose: sample and result path between sequencer and averager
// Assumes: one clock domain
// Notes: none
`timescale 1ns/1ps
interface adcseq_avg_if;
  logic smp_valid;
  logic [9:0] smp_data;
  logic avg_off;
  logic res_valid;
  logic [9:0] res_data;
  modport seq (output smp_valid, output smp_data, output avg_off,
    input res_valid, input res_data);
  modport avg (input smp_valid, input smp_data, input avg_off,
    output res_valid, output res_data);
endinterface : adcseq_avg_if

// >>> adcseq_conv_model.sv
// Purpose: converter stand-in that answers each start with one done
// Assumes: dly_i stays below the slot length less three
// Notes: data lines toggle while idle
`timescale 1ns/1ps
module adcseq_conv_model
(
  // clock
  input wire logic clk_i,
  // stimulus
  input wire logic start_i,
  input wire logic [4:0] dly_i,
  input wire logic [9:0] val_i,
  input wire logic vary_i,
  input wire logic ovr_i,
  // answer
  output logic done_o,
  output logic [9:0] data_o,
  output logic ovr_o
);
  logic [3:0] cnt_r = 4'h0;
  logic [4:0] wait_r = 5'h0;
  logic busy_r = 1'b0;
  initial
  begin
    done_o = 1'b0;
    ovr_o = 1'b0;
    data_o = 10'h155;
  end
  // =========================================================
  // conversion; in vary mode the low bits step through 0..15
  always @(posedge clk_i)
  begin
    done_o <= 1'b0;
    ovr_o <= 1'b0;
    data_o <= ~data_o;
    if (start_i)
    begin
      busy_r <= 1'b1;
      wait_r <= dly_i;
      cnt_r <= cnt_r + 4'h1;
    end
    else if (busy_r && wait_r != 5'h0)
      wait_r <= wait_r - 5'h1;
    else if (busy_r)
    begin
      busy_r <= 1'b0;
      done_o <= 1'b1;
      ovr_o <= ovr_i;
      data_o <= vary_i ? {val_i[9:4], cnt_r} : val_i;
    end
  end
endmodule : adcseq_conv_model

// >>> adcseq_pacer.sv
// Purpose: conversion slot timer and excitation phase
// Assumes: slot length of at least three cycles
// Notes: tick marks the start of each slot
`timescale 1ns/1ps
module adcseq_pacer
#(
  parameter int SLOT_CYC = adcseq_pkg::CONV_CYC
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // timing
  output logic tick_o,
  output logic [1:0] phase_o
);
  import adcseq_pkg::*;
  localparam int CW = $clog2(SLOT_CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(SLOT_CYC - 1);
  localparam logic [CW-1:0] THIRD = CW'(SLOT_CYC / 3);
  localparam logic [CW-1:0] TWO_THIRD = CW'(2 * (SLOT_CYC / 3));
  typedef struct packed {
    logic [CW-1:0] cnt;
    logic tick;
    logic [1:0] phase;
  } adcseq_pacer_t;
  adcseq_pacer_t r;
  adcseq_pacer_t n;
  always_comb
  begin
    n = r;
    n.tick = (r.cnt == LAST);
    n.cnt = n.tick ? '0 : CW'(r.cnt + 1'b1);
    // three excitation phases per slot, equal except that the last one takes any remainder
    if (n.cnt < THIRD)
      n.phase = ADCSEQ_EXC_BASE;
    else if (n.cnt < TWO_THIRD)
      n.phase = ADCSEQ_EXC_N1;
    else
      n.phase = ADCSEQ_EXC_N2;
  end
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      r <= '0;
    else
      r <= n;
  end
  assign tick_o = r.tick;
  assign phase_o = r.phase;
endmodule : adcseq_pacer

// >>> adcseq_pkg.sv
// Purpose: constants and types of the converter measurement sequencer
// Assumes: one 40 MHz clock, register port as a plain write strobe plus address
// Notes: timing figures are kept in their own unit and turned into cycles here
package adcseq_pkg;
  // =========================================================
  // timing
  localparam int CLK_PERIOD_PS = 25000;
  localparam int CONV_TIME_US10 = 7;
  localparam int CONV_CYC = CONV_TIME_US10 * 100000000 / CLK_PERIOD_PS;
  localparam int AVG_COUNT = 16;
  localparam int AVG_SHIFT = 4;
  localparam logic [9:0] CODE_MAX = 10'h3ff;
  // =========================================================
  // register map
  localparam logic [7:0] ADDR_RDG_BASE = 8'h20;
  localparam logic [7:0] ADDR_RDG_LAST = 8'h27;
  localparam logic [7:0] ADDR_CFG1 = 8'h40;
  localparam logic [7:0] ADDR_SEL = 8'h55;
  localparam logic [7:0] ADDR_CFG2 = 8'h73;
  localparam logic [7:0] CFG1_RST = 8'h00;
  localparam logic [7:0] SEL_RST = 8'h00;
  localparam logic [7:0] CFG2_RST = 8'h00;
  localparam logic [7:0] RDG_RST = 8'h00;
  localparam int CFG1_SUPPLY5V_BIT = 7;
  localparam int CFG2_AVGOFF_BIT = 4;
  localparam int CFG2_BYPASS_BIT = 5;
  localparam int CFG2_SINGLE_BIT = 6;
  localparam int SEL_LSB = 5;
  // =========================================================
  // channel codes
  typedef enum logic [2:0] {
    ADCSEQ_CH_2V5,
    ADCSEQ_CH_CORE,
    ADCSEQ_CH_SUPPLY,
    ADCSEQ_CH_5V,
    ADCSEQ_CH_12V,
    ADCSEQ_CH_REMOTE1,
    ADCSEQ_CH_LOCAL,
    ADCSEQ_CH_REMOTE2
  } adcseq_chan_t;
  typedef enum logic [1:0] {
    ADCSEQ_EXC_BASE,
    ADCSEQ_EXC_N1,
    ADCSEQ_EXC_N2
  } adcseq_exc_t;
endpackage : adcseq_pkg

// >>> adcseq_tb_top.sv
// Purpose: self-checking bench of the measurement sequencer
// Assumes: slot shortened to 30 cycles
// Notes: results checked against a queue of expected notes
`timescale 1ns/1ps
module adcseq_tb_top;
  import adcseq_pkg::*;
  localparam int CONV = 30;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic reg_wr_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [7:0] reg_wdata_i = 8'h00;
  logic [7:0] reg_rdata_o;
  logic conv_start_o, done, ovr, ovr_o, bypass_o, supply_5v_o, res_valid_o;
  logic [2:0] conv_chan_o, res_chan_o;
  logic [9:0] data, res_code_o;
  logic [1:0] exc_level_o;
  logic [4:0] dly = 5'h8;
  logic [9:0] val = 10'h0;
  logic vary = 1'b1;
  logic [12:0] expq[$];
  int errors = 0;
  int tests_run = 0;
  int gap = 0;
  int gap_exp = 0;
  int seed = 93;
  assign ovr = ovr_o;
  always #12.5 clk_i = ~clk_i;
  adcseq_top #(.CONV_CYCLES(CONV)) i_adcseq_top (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .conv_start_o(conv_start_o), .conv_chan_o(conv_chan_o),
    .conv_done_i(done), .conv_data_i(data), .conv_ovr_i(ovr), .bypass_o(bypass_o),
    .supply_5v_o(supply_5v_o), .exc_level_o(exc_level_o), .res_valid_o(res_valid_o),
    .res_chan_o(res_chan_o), .res_code_o(res_code_o));
  logic ovr_req = 1'b0;
  adcseq_conv_model i_adcseq_conv_model (.clk_i(clk_i), .start_i(conv_start_o),
    .dly_i(dly), .val_i(val), .vary_i(vary), .ovr_i(ovr_req), .done_o(done),
    .data_o(data), .ovr_o(ovr_o));
  // =========================================================
  // tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic final_report;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_i);
    reg_addr_i <= a;
    repeat (2) @(posedge clk_i);
    chk({8'h0, reg_rdata_o}, {8'h0, e});
  endtask : rd
  task automatic flush;
    int n;
    n = 0;
    @(posedge clk_i);
    while (res_valid_o !== 1'b1 && n < 2000)
    begin
      @(posedge clk_i);
      n++;
    end
    @(posedge clk_i);
  endtask : flush
  task automatic wait_q;
    int n;
    n = 0;
    while (expq.size() > 0 && n < 5000)
    begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 5000)
      errors++;
  endtask : wait_q
  // =========================================================
  // result monitor
  always @(posedge clk_i)
  begin
    gap <= gap + 1;
    if (res_valid_o === 1'b1)
    begin
      gap <= 1;
      if (expq.size() > 0)
      begin
        chk({3'h0, res_chan_o, res_code_o}, {3'h0, expq.pop_front()});
        if (gap_exp > 0)
          chk(16'(gap), 16'(gap_exp));
      end
    end
  end
  initial
  begin
    repeat (60000) @(posedge clk_i);
    errors++;
    final_report();
  end
  // =========================================================
  // main sequence
  initial
  begin
    logic [2:0] msk;
    val = 10'($random(seed));
    dly = 5'(($random(seed) & 15) + 8);
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    for (int i = 0; i < 9; i++)
      expq.push_back({3'(i), val[9:4], 4'h7});
    rd(ADDR_CFG1, 8'h00);
    rd(ADDR_CFG2, 8'h00);
    for (int i = 0; i < 8; i++)
      rd(8'(ADDR_RDG_BASE + i), RDG_RST);
    wait_q();
    wr(8'h20, 8'h5a);
    for (int i = 0; i < 8; i++)
      rd(8'(ADDR_RDG_BASE + i), {val[9:4], 2'h1});
    rd(8'h30, 8'h00);
    wr(ADDR_CFG1, 8'h80);
    wr(ADDR_CFG2, 8'h40);
    rd(ADDR_CFG2, 8'h40);
    gap_exp = 16 * CONV;
    for (int i = 0; i < 8; i++)
    begin
      wr(ADDR_SEL, {3'(i), 5'($random(seed))});
      flush();
      // old channel still shown until the new measurement starts
      @(posedge clk_i iff conv_start_o === 1'b1);
      msk = 3'h0;
      repeat (CONV) @(posedge clk_i) msk = msk | (3'h1 << exc_level_o);
      chk({supply_5v_o, msk}, {i == 2, (i == 5 || i == 7) ? 3'h7 : 3'h1});
      expq.push_back({3'(i), val[9:4], 4'h7});
      expq.push_back({3'(i), val[9:4], 4'h7});
      wait_q();
    end
    wr(ADDR_SEL, 8'h60);
    flush();
    expq.push_back({3'h3, val[9:4], 4'h7});
    repeat (100) @(posedge clk_i);
    wr(ADDR_SEL, 8'h80);
    expq.push_back({3'h4, val[9:4], 4'h7});
    wait_q();
    vary = 1'b0;
    val = 10'($random(seed));
    wr(ADDR_CFG2, 8'h50);
    flush();
    gap_exp = CONV;
    repeat (4) expq.push_back({3'h4, val});
    wait_q();
    ovr_req = 1'b1;
    flush();
    repeat (2) expq.push_back({3'h4, CODE_MAX});
    wait_q();
    ovr_req = 1'b0;
    wr(ADDR_CFG2, 8'h70);
    flush();
    repeat (CONV + 2) @(posedge clk_i);
    chk({15'h0, bypass_o}, 16'h1);
    wr(ADDR_CFG2, 8'h50);
    flush();
    repeat (CONV + 2) @(posedge clk_i);
    chk({15'h0, bypass_o}, 16'h0);
    final_report();
  end
endmodule : adcseq_tb_top

// >>> adcseq_top.sv
// Purpose: measurement sequencer around the multiplexed 10-bit converter
// Assumes: converter answers each start with one done before the next slot
// Notes: register reads answer one cycle after the address
`timescale 1ns/1ps
module adcseq_top
#(
  parameter int CONV_CYCLES = adcseq_pkg::CONV_CYC
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // register port
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  // converter
  output logic conv_start_o,
  output logic [2:0] conv_chan_o,
  input wire logic conv_done_i,
  input wire logic [9:0] conv_data_i,
  input wire logic conv_ovr_i,
  // analog front end
  output logic bypass_o,
  output logic supply_5v_o,
  output logic [1:0] exc_level_o,
  // results
  output logic res_valid_o,
  output logic [2:0] res_chan_o,
  output logic [9:0] res_code_o
);
  import adcseq_pkg::*;
  // =========================================================
  // reset release
  logic rst_s1_r;
  logic rst_s2_r;
  logic rst_n;
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end
    else
    begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end
  assign rst_n = rst_s2_r;
  // =========================================================
  // submodules
  logic tick;
  logic [1:0] phase;
  adcseq_avg_if aif ();
  adcseq_pacer #(.SLOT_CYC(CONV_CYCLES)) u_pacer (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .tick_o(tick),
    .phase_o(phase)
  );
  adcseq_avg u_avg (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .aif(aif)
  );
  // =========================================================
  // state
  typedef enum logic {ST_IDLE, ST_CONV} adcseq_state_t;
  typedef struct packed {
    adcseq_state_t state;
    logic [7:0] cfg1;
    logic [7:0] sel;
    logic [7:0] cfg2;
    logic [7:0][7:0] rdg;
    logic meas;
    logic lat_avg_off;
    logic lat_single;
    logic [2:0] scan;
    logic [2:0] chan;
    logic smp_valid;
    logic [9:0] smp_data;
    logic [7:0] rdata;
    logic conv_start;
    logic bypass;
    logic supply_5v;
    logic [1:0] exc;
    logic res_valid;
    logic [2:0] res_chan;
    logic [9:0] res_code;
  } adcseq_top_t;
  adcseq_top_t r;
  adcseq_top_t n;
  localparam adcseq_top_t TOP_RST = '{
    state: ST_IDLE, cfg1: CFG1_RST, sel: SEL_RST, cfg2: CFG2_RST,
    rdg: {8{RDG_RST}}, default: '0};
  function automatic logic is_remote(input logic [2:0] ch);
    is_remote = (ch == ADCSEQ_CH_REMOTE1) || (ch == ADCSEQ_CH_REMOTE2);
  endfunction : is_remote
  // =========================================================
  // next state
  always_comb
  begin
    n = r;
    n.conv_start = 1'b0;
    n.smp_valid = 1'b0;
    n.res_valid = 1'b0;
    if (reg_wr_i)
    begin
      if (reg_addr_i == ADDR_CFG1)
        n.cfg1 = reg_wdata_i;
      else if (reg_addr_i == ADDR_SEL)
        n.sel = reg_wdata_i;
      else if (reg_addr_i == ADDR_CFG2)
        n.cfg2 = reg_wdata_i;
    end
    if (reg_addr_i >= ADDR_RDG_BASE && reg_addr_i <= ADDR_RDG_LAST)
      n.rdata = r.rdg[reg_addr_i[2:0]];
    else if (reg_addr_i == ADDR_CFG1)
      n.rdata = r.cfg1;
    else if (reg_addr_i == ADDR_SEL)
      n.rdata = r.sel;
    else if (reg_addr_i == ADDR_CFG2)
      n.rdata = r.cfg2;
    else
      n.rdata = 8'h00;
    unique case (r.state)
      ST_IDLE:
        if (tick)
        begin
          // averaging-off, single and bypass modes and channel are taken only at a measurement start
          if (!r.meas)
          begin
            n.meas = 1'b1;
            n.lat_avg_off = r.cfg2[CFG2_AVGOFF_BIT];
            n.lat_single = r.cfg2[CFG2_SINGLE_BIT];
            n.bypass = r.cfg2[CFG2_BYPASS_BIT];
            n.chan = r.cfg2[CFG2_SINGLE_BIT] ? r.sel[SEL_LSB +: 3] : r.scan;
          end
          n.conv_start = 1'b1;
          n.state = ST_CONV;
        end
      ST_CONV:
        if (conv_done_i)
        begin
          n.smp_valid = 1'b1;
          n.smp_data = conv_ovr_i ? CODE_MAX : conv_data_i;
          n.state = ST_IDLE;
        end
    endcase
    if (aif.res_valid)
    begin
      n.res_valid = 1'b1;
      n.res_code = aif.res_data;
      n.res_chan = r.chan;
      n.rdg[r.chan] = aif.res_data[9:2];
      n.meas = 1'b0;
      n.scan = 3'(r.chan + 3'h1);
    end
    n.supply_5v = r.cfg1[CFG1_SUPPLY5V_BIT] && (n.chan == ADCSEQ_CH_SUPPLY);
    n.exc = is_remote(n.chan) ? phase : 2'(ADCSEQ_EXC_BASE);
  end
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      r <= TOP_RST;
    else
      r <= n;
  end
  // =========================================================
  // outputs
  assign aif.smp_valid = r.smp_valid;
  assign aif.smp_data = r.smp_data;
  assign aif.avg_off = r.lat_avg_off;
  assign reg_rdata_o = r.rdata;
  assign conv_start_o = r.conv_start;
  assign conv_chan_o = r.chan;
  assign bypass_o = r.bypass;
  assign supply_5v_o = r.supply_5v;
  assign exc_level_o = r.exc;
  assign res_valid_o = r.res_valid;
  assign res_chan_o = r.res_chan;
  assign res_code_o = r.res_code;
  // =========================================================
  // checks
  logic [4:0] smp_cnt_r;
  logic [31:0] gap_r;
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      smp_cnt_r <= '0;
      gap_r <= '0;
    end
    else
    begin
      if (res_valid_o)
        smp_cnt_r <= '0;
      else if (aif.smp_valid)
        smp_cnt_r <= 5'(smp_cnt_r + 1'b1);
      gap_r <= conv_start_o ? 32'h0 : gap_r + 32'h1;
    end
  end
  AST_AVG16: assert property (@(posedge clk_i) disable iff (!rst_n)
    res_valid_o && !r.lat_avg_off |-> smp_cnt_r == 5'(AVG_COUNT))
    else $error("averaged result not built from sixteen samples");
  AST_AVGOFF: assert property (@(posedge clk_i) disable iff (!rst_n)
    conv_done_i && r.state == ST_CONV && r.lat_avg_off |-> ##3 res_valid_o)
    else $error("averaging off did not store the single conversion");
  AST_BYPASS: assert property (@(posedge clk_i) disable iff (!rst_n)
    conv_start_o && $rose(r.meas) |-> bypass_o == $past(r.cfg2[CFG2_BYPASS_BIT]))
    else $error("bypass does not follow its configuration bit");
  AST_SINGLE: assert property (@(posedge clk_i) disable iff (!rst_n)
    conv_start_o && $rose(r.meas) && r.lat_single
      |-> conv_chan_o == $past(r.sel[SEL_LSB +: 3]))
    else $error("single channel mode converts the wrong channel");
  AST_PACE: assert property (@(posedge clk_i) disable iff (!rst_n)
    $rose(conv_start_o) && gap_r != 32'h0 |-> gap_r >= 32'(CONV_CYCLES - 1))
    else $error("conversions started faster than one per slot");
  AST_SAT: assert property (@(posedge clk_i) disable iff (!rst_n)
    conv_done_i && conv_ovr_i && r.state == ST_CONV && r.lat_avg_off
      |-> ##3 res_valid_o && res_code_o == CODE_MAX)
    else $error("over-range conversion did not saturate");
  AST_SCALE5: assert property (@(posedge clk_i) disable iff (!rst_n)
    conv_start_o && conv_chan_o == ADCSEQ_CH_SUPPLY && $past(r.cfg1[CFG1_SUPPLY5V_BIT])
      |-> supply_5v_o)
    else $error("supply channel lost its 5 V scaling");
  AST_EXC: assert property (@(posedge clk_i) disable iff (!rst_n)
    exc_level_o != 2'h3 && (is_remote(conv_chan_o) || exc_level_o == 2'h0))
    else $error("bad excitation level");
  AST_RDG: assert property (@(posedge clk_i) disable iff (!rst_n)
    res_valid_o |=> r.rdg[$past(res_chan_o)] == $past(res_code_o[9:2]))
    else $error("reading register not updated with result");
  AST_HOLD: assert property (@(posedge clk_i) disable iff (!rst_n)
    r.meas && !$rose(r.meas) |-> $stable(conv_chan_o) && $stable(bypass_o))
    else $error("channel or bypass changed inside a measurement");
  COV_SINGLE: cover property (@(posedge clk_i) disable iff (!rst_n)
    res_valid_o && r.lat_single);
  COV_AVGOFF: cover property (@(posedge clk_i) disable iff (!rst_n)
    res_valid_o && r.lat_avg_off);
  COV_REMOTE: cover property (@(posedge clk_i) disable iff (!rst_n)
    res_valid_o && res_chan_o == ADCSEQ_CH_REMOTE2);
  COV_SAT: cover property (@(posedge clk_i) disable iff (!rst_n)
    res_valid_o && res_code_o == CODE_MAX);
endmodule : adcseq_top
